// ==== hdl/tcp_pkg.sv ====
// Constants, register map and mode codes of the timer/counter/PWM channel
package tcp_pkg;
   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_PERIOD = 8'h04;
   localparam logic [7:0] OFS_CMP0 = 8'h08;
   localparam logic [7:0] OFS_CMP1 = 8'h0C;
   localparam logic [7:0] OFS_CAPTURE = 8'h10;
   localparam logic [7:0] OFS_COUNTER = 8'h14;
   localparam logic [7:0] OFS_DEADTIME = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1C;

   // ---------------------------------------------------------------
   // Control fields
   // ---------------------------------------------------------------
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_MODE_W = 3;
   localparam int CTRL_EN_BIT = 3;
   localparam int CTRL_ONESHOT_BIT = 4;
   localparam int CTRL_KILL_TRUE_BIT = 5;
   localparam int CTRL_KILL_COMP_BIT = 6;
   localparam int CTRL_PRESC_LSB = 8;
   localparam int PRESC_W = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // ---------------------------------------------------------------
   // Dead time fields
   // ---------------------------------------------------------------
   localparam int DT8_W = 8;
   localparam int DT16_W = 16;
   localparam int DT_COMP_LSB = 16;
   localparam logic [31:0] DEADTIME_RESET = 32'h0000_0000;

   // ---------------------------------------------------------------
   // Status bits
   // ---------------------------------------------------------------
   localparam int ST_RUN_BIT = 0;
   localparam int ST_KILL_BIT = 1;
   localparam int ST_TRUE_BIT = 2;
   localparam int ST_COMP_BIT = 3;

   // Galois feedback taps of the pseudo-random sequence
   localparam logic [15:0] LFSR_TAPS = 16'hB400;
   localparam int SYNC_N = 5;

   typedef enum logic [2:0]
   {
      MODE_TIMER = 3'h0,
      MODE_CAPTURE = 3'h1,
      MODE_QUAD = 3'h2,
      MODE_PWM = 3'h3,
      MODE_PWM_DEAD_TIME_MODE = 3'h4,
      MODE_PSEUDO_RANDOM_PWM_MODE = 3'h5,
      MODE_SHIFT = 3'h6,
      MODE_MOTOR = 3'h7
   } tcp_mode_t;
endpackage : tcp_pkg

// ==== hdl/tcp_dead_time.sv ====
// Dead time inserter producing a true/complement output pair
`timescale 1ns/10ps
module tcp_dead_time
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Raw waveform and delays
   input wire logic raw,
   input wire logic [15:0] dt_true,
   input wire logic [15:0] dt_comp,
   // Output pair
   output logic pwm_true,
   output logic pwm_comp
);
   logic raw_q, raw_d;
   logic [15:0] cnt_q, cnt_d;
   logic t_q, t_d;
   logic c_q, c_d;

   always_comb
   begin
      raw_d = raw;
      cnt_d = cnt_q;
      t_d = t_q;
      c_d = c_q;
      if (raw != raw_q)
      begin
         t_d = 1'b0;
         c_d = 1'b0;
         cnt_d = raw ? dt_true : dt_comp;
         if ((raw ? dt_true : dt_comp) == 16'h0000)
         begin
            t_d = raw;
            c_d = !raw;
         end
      end
      else if (cnt_q != 16'h0000)
      begin
         cnt_d = cnt_q - 16'h0001;
         if (cnt_q == 16'h0001)
         begin
            t_d = raw_q;
            c_d = !raw_q;
         end
      end
      else
      begin
         t_d = raw_q;
         c_d = !raw_q;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         raw_q <= 1'b0;
         cnt_q <= 16'h0000;
         t_q <= 1'b0;
         c_q <= 1'b0;
      end
      else
      begin
         raw_q <= raw_d;
         cnt_q <= cnt_d;
         t_q <= t_d;
         c_q <= c_d;
      end
   end

   assign pwm_true = t_q;
   assign pwm_comp = c_q;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);

   AST_DT_GAP: assert property ($changed(raw) && (raw ? dt_true : dt_comp) > 16'h0001 |=> (!t_q && !c_q) [*2]) else $error("dead gap too short");
   AST_NO_OVERLAP: assert property (!(t_q && c_q)) else $error("true and complement overlap");
endmodule : tcp_dead_time

// ==== hdl/tcp_channel.sv ====
// One timer/counter/PWM channel with an Avalon-MM register slave
// How it works
// - Counter width is a 16 or 32 bit parameter; period set by software.
// - A capture event copies the current count into the capture register.
// - At count equal period, counter halts (one-shot) or reloads.
// - Compare registers against count form the PWM duty cycle.
// - Mode field selects timer, capture, quad, PWM, dead-time, random, shift.
// - Dead-time PWM mode delays complementary edges by an 8-bit count.
// - Motor mode: asymmetric PWM, separate 16-bit dead times per output.
// - True and complement outputs separated by programmable dead-time offset.
// - In PWM modes the kill input forces outputs to preset levels.
`timescale 1ns/10ps
module tcp_channel
#(
   parameter int W = 16,
   parameter int MOTOR = 1
)
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Avalon-MM slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Event pins
   input wire logic capture_in,
   input wire logic phase_a,
   input wire logic phase_b,
   input wire logic shift_in,
   input wire logic kill_in,
   // PWM pair
   output logic pwm_true,
   output logic pwm_comp
);
   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   localparam int PRESC_W_L = tcp_pkg::PRESC_W;

   logic wait_q, wait_d;
   logic [31:0] rdata_q, rdata_d;
   logic [31:0] rmux;
   logic wr_go;
   logic [31:0] ctrl_q, ctrl_d;
   logic [31:0] dt_q, dt_d;
   logic [W-1:0] period_q, period_d;
   logic [W-1:0] cmp0_q, cmp0_d;
   logic [W-1:0] cmp1_q, cmp1_d;
   logic [W-1:0] capt_q, capt_d;
   logic [W-1:0] cnt_q, cnt_d;
   logic run_q, run_d;
   logic [PRESC_W_L-1:0] presc_q, presc_d;
   logic [tcp_pkg::SYNC_N-1:0] s1_q, s2_q, s3_q;
   logic tick, cap_rise, quad_step, quad_up, pwm_fam, kill_act;
   logic raw;
   logic [15:0] dtt, dtc;
   logic dt_true, dt_comp;
   logic true_q, true_d, comp_q, comp_d;
   tcp_pkg::tcp_mode_t mode;

   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
         begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : be_merge

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end
      else
      begin
         s1_q <= {kill_in, shift_in, phase_b, phase_a, capture_in};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // ---------------------------------------------------------------
   // Bus slave
   // ---------------------------------------------------------------
   assign wr_go = avs_write && !wait_q;

   always_comb
   begin
      case (avs_address)
         tcp_pkg::OFS_CTRL: rmux = ctrl_q;
         tcp_pkg::OFS_PERIOD: rmux = 32'(period_q);
         tcp_pkg::OFS_CMP0: rmux = 32'(cmp0_q);
         tcp_pkg::OFS_CMP1: rmux = 32'(cmp1_q);
         tcp_pkg::OFS_CAPTURE: rmux = 32'(capt_q);
         tcp_pkg::OFS_COUNTER: rmux = 32'(cnt_q);
         tcp_pkg::OFS_DEADTIME: rmux = dt_q;
         tcp_pkg::OFS_STATUS: rmux = {28'h000_0000, comp_q, true_q, kill_act, run_q};
         default: rmux = 32'h0000_0000;
      endcase
      wait_d = 1'b1;
      rdata_d = rdata_q;
      if ((avs_read || avs_write) && wait_q)
      begin
         wait_d = 1'b0;
         rdata_d = avs_read ? rmux : 32'h0000_0000;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         wait_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         wait_q <= wait_d;
         rdata_q <= rdata_d;
      end
   end

   // ---------------------------------------------------------------
   // Counter core
   // ---------------------------------------------------------------
   // Mode selection
   assign mode = tcp_pkg::tcp_mode_t'(ctrl_q[tcp_pkg::CTRL_MODE_LSB +: tcp_pkg::CTRL_MODE_W]);
   assign tick = run_q && (presc_q == ctrl_q[tcp_pkg::CTRL_PRESC_LSB +: PRESC_W_L]);
   assign cap_rise = s2_q[0] && !s3_q[0];
   assign quad_step = (s2_q[1] != s3_q[1]) || (s2_q[2] != s3_q[2]);
   assign quad_up = s2_q[1] ^ s3_q[2];

   always_comb
   begin
      ctrl_d = ctrl_q;
      period_d = period_q;
      cmp0_d = cmp0_q;
      cmp1_d = cmp1_q;
      dt_d = dt_q;
      cnt_d = cnt_q;
      capt_d = capt_q;
      run_d = run_q;
      presc_d = (!run_q || tick) ? '0 : presc_q + 1'b1;
      if (run_q)
      begin
         case (mode)
            tcp_pkg::MODE_QUAD:
            begin
               if (quad_step)
               begin
                  cnt_d = quad_up ? cnt_q + W'(1) : cnt_q - W'(1);
               end
            end
            tcp_pkg::MODE_PSEUDO_RANDOM_PWM_MODE:
            begin
               if (tick)
               begin
                  cnt_d = (cnt_q == '0) ? W'(1) :
                          ((cnt_q >> 1) ^ (cnt_q[0] ? W'(tcp_pkg::LFSR_TAPS) : '0));
               end
            end
            tcp_pkg::MODE_SHIFT:
            begin
               if (tick)
               begin
                  cnt_d = {cnt_q[W-2:0], s2_q[3]};
               end
            end
            default:
            begin
               if (tick && cnt_q == period_q)
               begin
                  if (ctrl_q[tcp_pkg::CTRL_ONESHOT_BIT])
                  begin
                     run_d = 1'b0;
                  end
                  else
                  begin
                     cnt_d = '0;
                  end
               end
               else if (tick)
               begin
                  cnt_d = cnt_q + W'(1);
               end
            end
         endcase
      end
      if (mode == tcp_pkg::MODE_CAPTURE && cap_rise)
      begin
         capt_d = cnt_q;
      end
      if (wr_go)
      begin
         case (avs_address)
            tcp_pkg::OFS_CTRL:
            begin
               ctrl_d = be_merge(ctrl_q, avs_writedata, avs_byteenable);
               run_d = ctrl_d[tcp_pkg::CTRL_EN_BIT];
            end
            tcp_pkg::OFS_PERIOD: period_d = W'(be_merge(32'(period_q), avs_writedata,
                                                        avs_byteenable));
            tcp_pkg::OFS_CMP0: cmp0_d = W'(be_merge(32'(cmp0_q), avs_writedata, avs_byteenable));
            tcp_pkg::OFS_CMP1: cmp1_d = W'(be_merge(32'(cmp1_q), avs_writedata, avs_byteenable));
            tcp_pkg::OFS_COUNTER: cnt_d = W'(be_merge(32'(cnt_q), avs_writedata, avs_byteenable));
            tcp_pkg::OFS_DEADTIME: dt_d = be_merge(dt_q, avs_writedata, avs_byteenable);
            default: ctrl_d = ctrl_q;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ctrl_q <= tcp_pkg::CTRL_RESET;
         dt_q <= tcp_pkg::DEADTIME_RESET;
         period_q <= '0;
         cmp0_q <= '0;
         cmp1_q <= '0;
         capt_q <= '0;
         cnt_q <= '0;
         run_q <= 1'b0;
         presc_q <= '0;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         dt_q <= dt_d;
         period_q <= period_d;
         cmp0_q <= cmp0_d;
         cmp1_q <= cmp1_d;
         capt_q <= capt_d;
         cnt_q <= cnt_d;
         run_q <= run_d;
         presc_q <= presc_d;
      end
   end

   // ---------------------------------------------------------------
   // Waveform and outputs
   // ---------------------------------------------------------------
   always_comb
   begin
      raw = 1'b0;
      dtt = 16'h0000;
      dtc = 16'h0000;
      case (mode)
         tcp_pkg::MODE_PWM, tcp_pkg::MODE_PSEUDO_RANDOM_PWM_MODE: raw = cnt_q < cmp0_q;
         tcp_pkg::MODE_PWM_DEAD_TIME_MODE:
         begin
            raw = cnt_q < cmp0_q;
            dtt = 16'(dt_q[tcp_pkg::DT8_W-1:0]);
            dtc = 16'(dt_q[tcp_pkg::DT8_W-1:0]);
         end
         tcp_pkg::MODE_MOTOR:
         begin
            if (MOTOR != 0)
            begin
               raw = (cnt_q >= cmp0_q) && (cnt_q < cmp1_q);
               dtt = dt_q[tcp_pkg::DT16_W-1:0];
               dtc = dt_q[tcp_pkg::DT_COMP_LSB +: tcp_pkg::DT16_W];
            end
            else
            begin
               raw = cnt_q < cmp0_q;
            end
         end
         tcp_pkg::MODE_SHIFT: raw = cnt_q[W-1];
         default: raw = 1'b0;
      endcase
   end

   tcp_dead_time u_dead_time
   (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .raw(raw),
      .dt_true(dtt),
      .dt_comp(dtc),
      .pwm_true(dt_true),
      .pwm_comp(dt_comp)
   );

   assign pwm_fam = (mode == tcp_pkg::MODE_PWM) || (mode == tcp_pkg::MODE_PWM_DEAD_TIME_MODE) ||
                    (mode == tcp_pkg::MODE_PSEUDO_RANDOM_PWM_MODE) || (mode == tcp_pkg::MODE_MOTOR);
   assign kill_act = s2_q[4] && pwm_fam;

   always_comb
   begin
      true_d = kill_act ? ctrl_q[tcp_pkg::CTRL_KILL_TRUE_BIT] : dt_true;
      comp_d = kill_act ? ctrl_q[tcp_pkg::CTRL_KILL_COMP_BIT] : dt_comp;
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         true_q <= 1'b0;
         comp_q <= 1'b0;
      end
      else
      begin
         true_q <= true_d;
         comp_q <= comp_d;
      end
   end

   assign pwm_true = true_q;
   assign pwm_comp = comp_q;
   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);

   sequence seq_req;
      (avs_read || avs_write) && wait_q;
   endsequence
   sequence seq_ack;
      !wait_q ##1 wait_q;
   endsequence

   AST_BUS_ACK: assert property (seq_req |=> seq_ack) else $error("bus answer not one cycle");
   AST_CAPTURE: assert property (mode == tcp_pkg::MODE_CAPTURE && cap_rise && !wr_go |=> capt_q == $past(cnt_q)) else $error("capture lost");
   AST_RELOAD: assert property (mode == tcp_pkg::MODE_TIMER && tick && cnt_q == period_q && !ctrl_q[tcp_pkg::CTRL_ONESHOT_BIT] && !wr_go |=> cnt_q == '0) else $error("no reload");
   AST_HALT: assert property (mode == tcp_pkg::MODE_TIMER && tick && cnt_q == period_q && ctrl_q[tcp_pkg::CTRL_ONESHOT_BIT] && !wr_go |=> !run_q && $stable(cnt_q)) else $error("no halt");
   AST_TIMER_INC: assert property (mode == tcp_pkg::MODE_TIMER && tick && cnt_q != period_q && !wr_go |=> cnt_q == $past(cnt_q) + W'(1)) else $error("bad increment");
   AST_KILL: assert property (kill_act |=> true_q == $past(ctrl_q[tcp_pkg::CTRL_KILL_TRUE_BIT]) && comp_q == $past(ctrl_q[tcp_pkg::CTRL_KILL_COMP_BIT])) else $error("kill ignored");
   AST_PWM_DUTY: assert property (mode == tcp_pkg::MODE_PWM && !kill_act && $stable(raw) [*4] |=> true_q == $past(raw)) else $error("duty mismatch");
   AST_NOKILL_TIMER: assert property (s2_q[4] && mode == tcp_pkg::MODE_TIMER |-> !kill_act) else $error("kill outside pwm");
endmodule : tcp_channel

// ==== testbench/tcp_stage_model.sv ====
// Behavioural power stage and event sources around one channel
`timescale 1ns/10ps
module tcp_stage_model
(
   // Clock
   input wire logic sys_clk,
   // Output pair from the channel
   input wire logic pwm_true,
   input wire logic pwm_comp,
   // Event sources
   output logic kill_in,
   output logic capture_in,
   output logic phase_a,
   output logic phase_b
);
   int overlap_n = 0;
   logic [1:0] seq [4] = '{2'b10, 2'b11, 2'b01, 2'b00};

   initial
   begin
      kill_in = 1'b0;
      capture_in = 1'b0;
      phase_a = 1'b0;
      phase_b = 1'b0;
   end

   // Shoot-through watch
   always @(posedge sys_clk)
   begin
      if (pwm_true === 1'b1 && pwm_comp === 1'b1)
         overlap_n <= overlap_n + 1;
   end

   // kill level held for whole cycles
   task automatic set_kill(input logic v);
      @(posedge sys_clk);
      kill_in <= v;
   endtask : set_kill

   task automatic fire_capture(input int n);
      @(posedge sys_clk);
      capture_in <= 1'b1;
      repeat (n) @(posedge sys_clk);
      capture_in <= 1'b0;
   endtask : fire_capture

   // Forward quadrature, one edge every four cycles
   task automatic quad_steps(input int n);
      for (int i = 0; i < n; i++)
      begin
         repeat (4) @(posedge sys_clk);
         {phase_a, phase_b} <= seq[i % 4];
      end
   endtask : quad_steps

   // Ten-cycle window: high time of true output, time with both low
   task automatic measure(output int hi, output int gap);
      hi = 0;
      gap = 0;
      repeat (10)
      begin
         @(posedge sys_clk);
         hi += (pwm_true === 1'b1);
         gap += (pwm_true === 1'b0 && pwm_comp === 1'b0);
      end
   endtask : measure
endmodule : tcp_stage_model

// ==== testbench/timer_counter_pwm_channel_tb.sv ====
// Self-checking bench of one timer/counter/PWM channel
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
   $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module timer_counter_pwm_channel_tb;
   localparam logic [31:0] ALL = 32'hFFFF_FFFF;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic kill_in, capture_in, phase_a, phase_b, pwm_true, pwm_comp;
   logic shift_in = 1'b0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] exp_q [$];
   logic [31:0] msk_q [$];
   int bad_count = 0;
   int checks_done = 0;
   int hi, gap, c;

   always #4 sys_clk = ~sys_clk;

   tcp_channel #(.W(16), .MOTOR(1)) u_tcp_channel
   (
      .sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .capture_in(capture_in), .phase_a(phase_a), .phase_b(phase_b), .shift_in(shift_in),
      .kill_in(kill_in), .pwm_true(pwm_true), .pwm_comp(pwm_comp)
   );

   tcp_stage_model u_tcp_stage_model
   (
      .sys_clk(sys_clk), .pwm_true(pwm_true), .pwm_comp(pwm_comp), .kill_in(kill_in),
      .capture_in(capture_in), .phase_a(phase_a), .phase_b(phase_b)
   );

   // ---------------------------------------------------------------
   // Bus tasks and read monitor
   // ---------------------------------------------------------------
   task automatic report_and_stop;
      if (bad_count == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : report_and_stop

   task automatic wait_ack;
      int n;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 50);
      if (avs_waitrequest !== 1'b0)
      begin
         bad_count++;
         report_and_stop();
      end
   endtask : wait_ack

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      wait_ack();
      avs_write <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      @(posedge sys_clk);
      avs_address <= a;
      avs_read <= 1'b1;
      wait_ack();
      avs_read <= 1'b0;
   endtask : rd

   task automatic settle_measure;
      repeat (25) @(posedge sys_clk);
      u_tcp_stage_model.measure(hi, gap);
   endtask : settle_measure

   always @(posedge sys_clk)
   begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0)
      begin
         `CHK(avs_readdata & msk_q[0], exp_q[0] & msk_q[0])
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
   end

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial
   begin
      void'($urandom(6));
      repeat (16) @(posedge sys_clk);
      nrst <= 1'b1;
      rd(tcp_pkg::OFS_CTRL, tcp_pkg::CTRL_RESET, ALL);
      rd(tcp_pkg::OFS_DEADTIME, tcp_pkg::DEADTIME_RESET, ALL);
      wr(8'h20, 32'h1234_5678);
      rd(8'h20, 32'h0000_0000, ALL);
      wr(tcp_pkg::OFS_PERIOD, 32'hABCD_1234);
      rd(tcp_pkg::OFS_PERIOD, 32'h0000_1234, ALL);
      avs_byteenable <= 4'h1;
      wr(tcp_pkg::OFS_PERIOD, 32'h0000_55AA);
      rd(tcp_pkg::OFS_PERIOD, 32'h0000_12AA, ALL);
      avs_byteenable <= 4'hF;
      for (int m = 0; m < 8; m++)
      begin
         wr(tcp_pkg::OFS_CTRL, 32'(m));
         rd(tcp_pkg::OFS_CTRL, 32'(m), 32'h0000_0007);
      end
      // One-shot timer stops on the period value
      wr(tcp_pkg::OFS_PERIOD, 32'h0000_0005);
      wr(tcp_pkg::OFS_COUNTER, 32'h0000_0000);
      wr(tcp_pkg::OFS_CTRL, 32'h0000_0018);
      repeat (20) @(posedge sys_clk);
      rd(tcp_pkg::OFS_COUNTER, 32'h0000_0005, ALL);
      rd(tcp_pkg::OFS_STATUS, 32'h0000_0000, 32'h0000_0001);
      // Capture of a halted count
      wr(tcp_pkg::OFS_PERIOD, 32'h0000_0007);
      wr(tcp_pkg::OFS_COUNTER, 32'h0000_0000);
      wr(tcp_pkg::OFS_CTRL, 32'h0000_0019);
      repeat (20) @(posedge sys_clk);
      u_tcp_stage_model.fire_capture(4);
      repeat (8) @(posedge sys_clk);
      rd(tcp_pkg::OFS_CAPTURE, 32'h0000_0007, ALL);
      // Quadrature decoding
      wr(tcp_pkg::OFS_CTRL, 32'h0000_000A);
      wr(tcp_pkg::OFS_COUNTER, 32'h0000_0000);
      u_tcp_stage_model.quad_steps(6);
      repeat (8) @(posedge sys_clk);
      rd(tcp_pkg::OFS_COUNTER, 32'h0000_0006, ALL);
      // Shift register fills with the serial input
      shift_in <= 1'b1;
      wr(tcp_pkg::OFS_CTRL, 32'h0000_000E);
      repeat (20) @(posedge sys_clk);
      rd(tcp_pkg::OFS_COUNTER, 32'h0000_FFFF, ALL);
      shift_in <= 1'b0;
      // PWM duty from random compare values
      wr(tcp_pkg::OFS_PERIOD, 32'h0000_0009);
      wr(tcp_pkg::OFS_COUNTER, 32'h0000_0000);
      wr(tcp_pkg::OFS_CTRL, 32'h0000_000B);
      repeat (3)
      begin
         c = $urandom % 10;
         wr(tcp_pkg::OFS_CMP0, 32'(c));
         settle_measure();
         `CHK(hi, c)
         `CHK(gap, 0)
      end
      // Kill forces preset levels in the PWM modes only, not in timer mode
      wr(tcp_pkg::OFS_CTRL, 32'h0000_002B);
      u_tcp_stage_model.set_kill(1'b1);
      repeat (6) @(posedge sys_clk);
      `CHK({pwm_true, pwm_comp}, 2'b10)
      rd(tcp_pkg::OFS_STATUS, 32'h0000_0002, 32'h0000_0002);
      wr(tcp_pkg::OFS_CTRL, 32'h0000_0028);
      repeat (6) @(posedge sys_clk);
      `CHK({pwm_true, pwm_comp}, 2'b01)
      u_tcp_stage_model.set_kill(1'b0);
      // Dead-time PWM, then motor mode with separate delays
      wr(tcp_pkg::OFS_CMP0, 32'h0000_0004);
      wr(tcp_pkg::OFS_DEADTIME, 32'h0000_0003);
      wr(tcp_pkg::OFS_CTRL, 32'h0000_000C);
      settle_measure();
      `CHK(gap >= 6, 1'b1)
      wr(tcp_pkg::OFS_CMP0, 32'h0000_0002);
      wr(tcp_pkg::OFS_CMP1, 32'h0000_0006);
      wr(tcp_pkg::OFS_DEADTIME, 32'h0000_0000);
      wr(tcp_pkg::OFS_CTRL, 32'h0000_000F);
      settle_measure();
      `CHK(hi, 4)
      wr(tcp_pkg::OFS_DEADTIME, 32'h0002_0001);
      settle_measure();
      `CHK(gap >= 3, 1'b1)
      `CHK(u_tcp_stage_model.overlap_n, 0)
      report_and_stop();
   end

   initial
   begin
      repeat (20000) @(posedge sys_clk);
      bad_count++;
      report_and_stop();
   end
endmodule : timer_counter_pwm_channel_tb
